// file: hdl/oled_cmd_pkg.sv
// Shared constants, types and register map for the display command block.
`default_nettype none

package oled_cmd_pkg;

  // ==========================================================================
  // Register map (byte offsets on the bus)
  localparam logic [7:0] CMD_OFFSET     = 8'h00;
  localparam logic [7:0] DATA_OFFSET    = 8'h04;
  localparam logic [7:0] POINTER_OFFSET = 8'h08;
  localparam logic [7:0] CONFIG_OFFSET  = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET  = 8'h10;
  localparam logic [7:0] ROWQ_OFFSET    = 8'h14;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_ADDR_MODE   = 8'h20;
  localparam logic [7:0] OP_COL_WINDOW  = 8'h21;
  localparam logic [7:0] OP_PAGE_WINDOW = 8'h22;
  localparam logic [7:0] OP_CONTRAST    = 8'h81;
  localparam logic [7:0] OP_MUX         = 8'hA8;
  localparam logic [7:0] OP_REF_SELECT  = 8'hAD;
  localparam logic [7:0] OP_OFFSET      = 8'hD3;
  localparam logic [7:0] OP_CLK_DIV     = 8'hD5;
  localparam logic [7:0] OP_PRECHARGE   = 8'hD9;
  localparam logic [7:0] OP_ROW_PINS    = 8'hDA;
  localparam logic [7:0] OP_DESELECT    = 8'hDB;

  // ==========================================================================
  // Field positions and limits
  localparam int         STATUS_OFF_BIT  = 6;
  localparam int         REF_INTERNAL_BIT = 4;
  localparam logic [5:0] MUX_MIN         = 6'h0F;
  localparam logic [6:0] SEG_LAST        = 7'h7F;
  localparam logic [5:0] ROW_LAST        = 6'h3F;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] CONTRAST_RESET  = 8'h7F;
  localparam logic [5:0] MUX_RESET       = 6'h3F;
  localparam logic [6:0] COL_START_RESET = 7'h00;
  localparam logic [6:0] COL_END_RESET   = 7'h7F;
  localparam logic [2:0] PAGE_START_RESET = 3'h0;
  localparam logic [2:0] PAGE_END_RESET  = 3'h7;

  typedef enum logic [1:0] {
    ADDR_HORIZ = 2'b00,
    ADDR_VERT  = 2'b01,
    ADDR_PAGE  = 2'b10
  } addr_mode_type;

  typedef enum logic [2:0] {
    DEC_IDLE = 3'b001,
    DEC_ARG1 = 3'b010,
    DEC_ARG2 = 3'b100
  } dec_state_type;

  typedef struct packed {
    logic [6:0] col_start;
    logic [6:0] col_end;
    logic [2:0] page_start;
    logic [2:0] page_end;
  } window_type;

  typedef struct packed {
    logic [5:0] start_line;
    logic [5:0] offset;
    logic [5:0] mux;
    logic       scan_reverse;
  } row_map_cfg_type;

endpackage

`default_nettype wire

// file: hdl/addr_pointer.sv
// Column and page pointer of the frame memory with window wrap.
`default_nettype none

module addr_pointer
  import oled_cmd_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire addr_mode_type addr_mode,
  input  wire window_type    window,
  input  wire logic          load_col,
  input  wire logic [6:0]    col_value,
  input  wire logic          load_page,
  input  wire logic [2:0]    page_value,
  input  wire logic          access,
  output logic [6:0]         col_ptr,
  output logic [2:0]         page_ptr
);

  logic col_at_end;
  logic page_at_end;

  assign col_at_end  = (col_ptr == window.col_end);
  assign page_at_end = (page_ptr == window.page_end);

  // ==========================================================================
  // Column pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      col_ptr <= COL_START_RESET;
    end else if (load_col) begin
      col_ptr <= col_value; // [R17]
    end else if (access) begin
      case (addr_mode)
        ADDR_VERT: begin
          if (page_at_end) begin
            col_ptr <= col_at_end ? window.col_start : col_ptr + 7'h01;
          end
        end
        default: begin
          col_ptr <= col_at_end ? window.col_start : col_ptr + 7'h01; // [R03]
        end
      endcase
    end
  end

  // ==========================================================================
  // Page pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_ptr <= PAGE_START_RESET;
    end else if (load_page) begin
      page_ptr <= page_value; // [R01] [R12]
    end else if (access) begin
      case (addr_mode)
        ADDR_HORIZ: begin
          if (col_at_end) begin
            page_ptr <= page_at_end ? window.page_start : page_ptr + 3'h1; // [R03]
          end
        end
        ADDR_VERT: begin
          page_ptr <= page_at_end ? window.page_start : page_ptr + 3'h1; // [R02]
        end
        default: begin
          page_ptr <= page_ptr;
        end
      endcase
    end
  end

  // ==========================================================================
  // Checks
  AST_VERT_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    access && !load_page && addr_mode == ADDR_VERT && page_at_end
    |=> page_ptr == $past(window.page_start)) // [R02]
    else $error("vertical page pointer did not wrap to start");

  AST_HORIZ_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    access && !load_col && !load_page && addr_mode == ADDR_HORIZ
    && col_at_end && page_at_end
    |=> col_ptr == $past(window.col_start)
        && page_ptr == $past(window.page_start)) // [R03]
    else $error("horizontal pointers did not wrap to window start");

  COV_VERT_WRAP: cover property (@(posedge hclk) disable iff (!hresetn)
    access && addr_mode == ADDR_VERT && page_at_end && col_at_end);

endmodule // addr_pointer

`default_nettype wire

// file: hdl/row_mapper.sv
// Maps each row driver output onto a frame memory row.
`default_nettype none

module row_mapper
  import oled_cmd_pkg::*;
#(
  parameter int ROWS = 64
)
(
  input  wire row_map_cfg_type cfg,
  input  wire logic [5:0]      scan_index,
  input  wire logic [5:0]      query_index,
  output logic [ROWS-1:0]      row_select_vector,
  output logic [6:0]           scan_map,
  output logic [6:0]           query_map
);

  // Returns {selected, memory row}; the 6-bit sums wrap modulo 64.
  function automatic logic [6:0] map_row(input logic [5:0] index,
                                         input row_map_cfg_type c);
    logic [5:0] phys;
    logic [5:0] line;
    phys = c.scan_reverse ? ROW_LAST - index : index;
    line = phys + c.offset;
    return {line <= c.mux, 6'(line + c.start_line)}; // [R18] [R13]
  endfunction

  assign scan_map  = map_row(scan_index, cfg);
  assign query_map = map_row(query_index, cfg);

  // ==========================================================================
  // Per-output selection: outputs whose mapped line (after reverse and offset) is past the ratio stay unselected.
  genvar i;
  generate
    for (i = 0; i < ROWS; i++) begin : g_row
      logic [6:0] m;
      assign m = map_row(6'(i), cfg);
      assign row_select_vector[i] = m[6]; // [R09] [R18]
    end
  endgenerate

endmodule // row_mapper

`default_nettype wire

// file: hdl/oled_display_command_config.sv
// Command interpreter and display configuration with an AHB-Lite port.
//
// Contract
// [R01] Page window: opcode, start, end; load page pointer.
// [R02] Vertical mode: page advances, wraps end to start.
// [R03] Horizontal mode: after last cell both pointers restart.
// [R04] Start line opcodes load six-bit first row.
// [R05] Contrast byte follows; current rises with value.
// [R06] Segment remap affects only later memory writes.
// [R07] Force-all-on lights every pixel; resume follows memory.
// [R08] Normal lights on one, inverse on zero.
// [R09] Ratio 16 to 63, default 63, limits outputs; the code accepts mux values 15 to 63 (16 to 64 rows).
// [R10] Store internal or external reference current choice.
// [R11] Off grounds segments, floats rows; on enables drive.
// [R12] Page mode opcodes set page from low bits.
// [R13] Scan direction flips image at once.
// [R14] Offset command: second byte holds six-bit offset.
// [R15] Host sends 64 minus n to shift away.
// [R16] Mode codes: 00 horizontal, 01 vertical, 10 page.
// [R17] Column window: opcode, start, end; load column pointer.
// [R18] Row is offset plus start modulo 64.
// [R19] Multi-byte commands apply only after final byte.
//
// Local design decisions: the address map and register access over AHB-Lite.
`default_nettype none

module oled_display_command_config
  import oled_cmd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        pixel_mem_bit,
  input  wire logic [5:0]  scan_row_index,
  output logic             pixel_lit,
  output logic [7:0]       contrast_level,
  output logic             reference_current_external,
  output logic             display_on,
  output logic             segment_ground,
  output logic             row_output_hiz,
  output logic [63:0]      row_driver_output,
  output logic [5:0]       scan_ram_row,
  output logic             scan_row_active,
  output logic             mem_write_strobe,
  output logic [6:0]       mem_segment,
  output logic [2:0]       mem_page,
  output logic [7:0]       mem_write_data
);

  // Number of parameter bytes that follow an opcode.
  function automatic logic [1:0] arg_count(input logic [7:0] op);
    case (op)
      OP_COL_WINDOW, OP_PAGE_WINDOW: return 2'd2;
      OP_ADDR_MODE, OP_CONTRAST, OP_MUX, OP_REF_SELECT, OP_OFFSET,
      OP_CLK_DIV, OP_PRECHARGE, OP_ROW_PINS, OP_DESELECT: return 2'd1;
      default: return 2'd0;
    endcase
  endfunction

  // ==========================================================================
  // Bus slave
  logic          dp_write_reg;
  logic          dp_read_reg;
  logic [7:0]    dp_addr_reg;
  logic          rd_ready_reg;
  logic [31:0]   hrdata_reg;
  logic [31:0]   read_next;
  logic          ap_valid;

  assign ap_valid  = hsel && htrans[1] && hready;
  // Reads take one wait state so that a write in the cycle before is seen.
  assign hreadyout = !dp_read_reg || rd_ready_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_read_reg  <= 1'b0;
      dp_addr_reg  <= 8'h00;
    end else if (ap_valid) begin
      dp_write_reg <= hwrite;
      dp_read_reg  <= !hwrite;
      dp_addr_reg  <= {haddr[7:2], 2'b00};
    end else if (hready) begin
      dp_write_reg <= 1'b0;
      dp_read_reg  <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ready_reg <= 1'b0;
      hrdata_reg   <= 32'h0000_0000;
    end else begin
      rd_ready_reg <= dp_read_reg && !rd_ready_reg;
      if (dp_read_reg && !rd_ready_reg) begin
        hrdata_reg <= read_next;
      end
    end
  end

  logic       cmd_wr;
  logic       data_wr;
  logic       rowq_wr;
  logic [7:0] cmd_byte;

  assign cmd_wr   = dp_write_reg && dp_addr_reg == CMD_OFFSET;
  assign data_wr  = dp_write_reg && dp_addr_reg == DATA_OFFSET;
  assign rowq_wr  = dp_write_reg && dp_addr_reg == ROWQ_OFFSET;
  assign cmd_byte = hwdata[7:0];

  // ==========================================================================
  // Command decoder
  dec_state_type dec_state_reg;
  logic [7:0]    pending_op_reg;
  logic [6:0]    arg1_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_state_reg  <= DEC_IDLE;
      pending_op_reg <= 8'h00;
      arg1_reg       <= 7'h00;
    end else if (cmd_wr) begin
      case (dec_state_reg)
        DEC_IDLE: begin
          pending_op_reg <= cmd_byte;
          if (arg_count(cmd_byte) != 2'd0) begin
            dec_state_reg <= DEC_ARG1; // [R19]
          end
        end
        DEC_ARG1: begin
          arg1_reg <= cmd_byte[6:0];
          dec_state_reg <= (arg_count(pending_op_reg) == 2'd2)
                           ? DEC_ARG2 : DEC_IDLE; // [R19]
        end
        DEC_ARG2: begin
          dec_state_reg <= DEC_IDLE;
        end
        default: begin
          dec_state_reg <= DEC_IDLE;
        end
      endcase
    end
  end

  logic idle_op;
  logic arg1_op;
  logic arg2_op;

  assign idle_op = cmd_wr && dec_state_reg == DEC_IDLE;
  assign arg1_op = cmd_wr && dec_state_reg == DEC_ARG1;
  assign arg2_op = cmd_wr && dec_state_reg == DEC_ARG2;

  // ==========================================================================
  // Configuration state
  addr_mode_type   addr_mode_reg;
  window_type      window_reg;
  row_map_cfg_type map_reg;
  logic [7:0]      contrast_reg;
  logic            seg_remap_reg;
  logic            force_all_reg;
  logic            inverse_reg;
  logic            ref_internal_reg;
  logic            display_on_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_mode_reg    <= ADDR_PAGE;
      window_reg       <= {COL_START_RESET, COL_END_RESET,
                           PAGE_START_RESET, PAGE_END_RESET};
      map_reg          <= {6'h00, 6'h00, MUX_RESET, 1'b0};
      contrast_reg     <= CONTRAST_RESET;
      seg_remap_reg    <= 1'b0;
      force_all_reg    <= 1'b0;
      inverse_reg      <= 1'b0;
      ref_internal_reg <= 1'b0;
      display_on_reg   <= 1'b0;
    end else if (idle_op) begin
      case (cmd_byte[7:4])
        4'h4, 4'h5, 4'h6, 4'h7: map_reg.start_line <= cmd_byte[5:0]; // [R04]
        4'hA: begin
          case (cmd_byte[3:0])
            4'h0, 4'h1: seg_remap_reg  <= cmd_byte[0]; // [R06]
            4'h4, 4'h5: force_all_reg  <= cmd_byte[0]; // [R07]
            4'h6, 4'h7: inverse_reg    <= cmd_byte[0]; // [R08]
            4'hE, 4'hF: display_on_reg <= cmd_byte[0]; // [R11]
            default: ;
          endcase
        end
        4'hC: map_reg.scan_reverse <= cmd_byte[3]; // [R13]
        default: ;
      endcase
    end else if (arg1_op) begin
      case (pending_op_reg)
        OP_ADDR_MODE: begin
          if (cmd_byte[1:0] != 2'b11) begin
            addr_mode_reg <= addr_mode_type'(cmd_byte[1:0]); // [R16]
          end
        end
        OP_CONTRAST: contrast_reg <= cmd_byte; // [R05]
        OP_MUX: begin
          if (cmd_byte[5:0] >= MUX_MIN) begin
            map_reg.mux <= cmd_byte[5:0]; // [R09]
          end
        end
        OP_REF_SELECT: ref_internal_reg <= cmd_byte[REF_INTERNAL_BIT]; // [R10]
        OP_OFFSET: map_reg.offset <= cmd_byte[5:0]; // [R14] [R15]
        default: ;
      endcase
    end else if (arg2_op) begin
      if (pending_op_reg == OP_COL_WINDOW) begin
        window_reg.col_start <= arg1_reg; // [R17] [R19]
        window_reg.col_end   <= cmd_byte[6:0];
      end else begin
        window_reg.page_start <= arg1_reg[2:0]; // [R01] [R19]
        window_reg.page_end   <= cmd_byte[2:0];
      end
    end
  end

  // ==========================================================================
  // Pointers
  logic       load_col;
  logic [6:0] col_value;
  logic       load_page;
  logic [2:0] page_value;
  logic [6:0] col_ptr;
  logic [2:0] page_ptr;
  logic       page_mode_op;

  assign page_mode_op = idle_op && addr_mode_reg == ADDR_PAGE;
  assign load_col  = (arg2_op && pending_op_reg == OP_COL_WINDOW)
                   || (page_mode_op && cmd_byte[7:5] == 3'b000);
  assign col_value = arg2_op ? arg1_reg
                   : cmd_byte[4] ? {cmd_byte[2:0], col_ptr[3:0]}
                   : {col_ptr[6:4], cmd_byte[3:0]};
  assign load_page = (arg2_op && pending_op_reg == OP_PAGE_WINDOW)
                   || (page_mode_op && cmd_byte[7:3] == 5'b10110); // [R12]
  assign page_value = arg2_op ? arg1_reg[2:0] : cmd_byte[2:0];

  addr_pointer u_addr_pointer (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .addr_mode  (addr_mode_reg),
    .window     (window_reg),
    .load_col   (load_col),
    .col_value  (col_value),
    .load_page  (load_page),
    .page_value (page_value),
    .access     (data_wr),
    .col_ptr    (col_ptr),
    .page_ptr   (page_ptr)
  );

  // The remap is applied on the way into memory, so stored data keep
  // whatever mapping was in force when they were written.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_write_strobe <= 1'b0;
      mem_segment      <= 7'h00;
      mem_page         <= 3'h0;
      mem_write_data   <= 8'h00;
    end else begin
      mem_write_strobe <= data_wr;
      if (data_wr) begin
        mem_segment    <= seg_remap_reg ? SEG_LAST - col_ptr : col_ptr; // [R06]
        mem_page       <= page_ptr;
        mem_write_data <= hwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Row mapping and panel drive
  logic [5:0]  query_index_reg;
  logic [63:0] row_select;
  logic [6:0]  scan_map;
  logic [6:0]  query_map;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      query_index_reg <= 6'h00;
    end else if (rowq_wr) begin
      query_index_reg <= hwdata[5:0];
    end
  end

  row_mapper #(.ROWS(64)) u_row_mapper (
    .cfg               (map_reg),
    .scan_index        (scan_row_index),
    .query_index       (query_index_reg),
    .row_select_vector (row_select),
    .scan_map          (scan_map),
    .query_map         (query_map)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pixel_lit         <= 1'b0;
      row_driver_output <= 64'h0;
      scan_ram_row      <= 6'h00;
      scan_row_active   <= 1'b0;
      segment_ground    <= 1'b1;
      row_output_hiz    <= 1'b1;
    end else begin
      pixel_lit <= display_on_reg
                   && (force_all_reg || (pixel_mem_bit ^ inverse_reg)); // [R07] [R08]
      row_driver_output <= display_on_reg ? row_select : 64'h0; // [R11] [R13]
      scan_ram_row      <= scan_map[5:0]; // [R18]
      scan_row_active   <= display_on_reg && scan_map[6];
      segment_ground    <= !display_on_reg; // [R11]
      row_output_hiz    <= !display_on_reg;
    end
  end

  assign contrast_level             = contrast_reg; // [R05]
  assign reference_current_external = !ref_internal_reg;
  assign display_on                 = display_on_reg;

  // ==========================================================================
  // Register read mux
  always_comb begin
    read_next = 32'h0000_0000;
    case (dp_addr_reg)
      CMD_OFFSET: read_next = {23'h0, dec_state_reg != DEC_IDLE,
                               pending_op_reg};
      POINTER_OFFSET: read_next = {14'h0, addr_mode_reg, 5'h0, page_ptr,
                                   1'b0, col_ptr};
      CONFIG_OFFSET: read_next = {contrast_reg, 2'b0, map_reg.mux, 2'b0,
                                  map_reg.offset, 2'b0, map_reg.start_line};
      STATUS_OFFSET: read_next = {25'h0, !display_on_reg, 1'b0,
                                  ref_internal_reg, map_reg.scan_reverse,
                                  seg_remap_reg, inverse_reg, force_all_reg};
      ROWQ_OFFSET: read_next = {10'h0, query_index_reg, 7'h0, query_map[6],
                                2'b0, query_map[5:0]};
      default: read_next = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_PAGE_LOAD: assert property (arg2_op && pending_op_reg == OP_PAGE_WINDOW
    |=> page_ptr == $past(arg1_reg[2:0])) // [R01]
    else $error("page window did not load the page pointer");
  AST_COL_LOAD: assert property (arg2_op && pending_op_reg == OP_COL_WINDOW
    |=> col_ptr == $past(arg1_reg)
        && window_reg.col_end == $past(cmd_byte[6:0])) // [R17]
    else $error("column window did not load pointer and end");
  AST_START_LINE: assert property (idle_op && cmd_byte[7:6] == 2'b01
    |=> map_reg.start_line == $past(cmd_byte[5:0])) // [R04]
    else $error("start line not loaded");
  AST_CONTRAST: assert property (arg1_op && pending_op_reg == OP_CONTRAST
    |=> contrast_level == $past(cmd_byte)) // [R05]
    else $error("contrast not loaded");
  AST_REMAP: assert property (data_wr && seg_remap_reg
    |=> mem_write_strobe && mem_segment == SEG_LAST - $past(col_ptr)) // [R06]
    else $error("remapped segment wrong");
  AST_FORCE_ON: assert property (display_on_reg && force_all_reg
    |=> pixel_lit) // [R07]
    else $error("forced pixel not lit");
  AST_INVERSE: assert property (display_on_reg && !force_all_reg
    && inverse_reg |=> pixel_lit == !$past(pixel_mem_bit)) // [R08]
    else $error("inverse pixel wrong");
  AST_MUX_RANGE: assert property (map_reg.mux >= MUX_MIN) // [R09]
    else $error("ratio below minimum");
  AST_DISPLAY_OFF: assert property (!display_on_reg
    |=> segment_ground && row_output_hiz && row_driver_output == 64'h0
        && !pixel_lit) // [R11]
    else $error("display off drive wrong");
  AST_PAGE_MODE: assert property (page_mode_op && cmd_byte[7:3] == 5'b10110
    |=> page_ptr == $past(cmd_byte[2:0])) // [R12]
    else $error("page start opcode ignored");
  AST_SCAN_FLIP: assert property (idle_op && cmd_byte == 8'hC8
    |=> map_reg.scan_reverse ##1 (!display_on_reg || row_driver_output[0]
        == ($past(map_reg.offset) + 6'h3F <= map_reg.mux))) // [R13]
    else $error("scan reverse not applied at once");
  AST_OFFSET: assert property (arg1_op && pending_op_reg == OP_OFFSET
    |=> map_reg.offset == $past(cmd_byte[5:0])) // [R14]
    else $error("offset not loaded");
  AST_MODE: assert property (arg1_op && pending_op_reg == OP_ADDR_MODE
    && cmd_byte[1:0] == 2'b01 |=> addr_mode_reg == ADDR_VERT) // [R16]
    else $error("vertical mode code not decoded");
  AST_HOLD: assert property (idle_op && cmd_byte == OP_COL_WINDOW
    |=> $stable(window_reg) [*2]) // [R19]
    else $error("window changed before final byte");

  COV_WINDOW: cover property (arg2_op && pending_op_reg == OP_PAGE_WINDOW);
  COV_OFFSET: cover property (arg1_op && pending_op_reg == OP_OFFSET);
  COV_READ: cover property (dp_read_reg && rd_ready_reg);

endmodule // oled_display_command_config

`default_nettype wire

// file: dv/host_model.sv
// Host processor model issuing single word transfers on the register bus.
`default_nettype none
module host_model (
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        rdy_s;
  logic [31:0] rd_s;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  always @(posedge hclk) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end
  // After the data phase the write data is inverted, so a design that
  // samples it late sees a wrong value rather than a lucky stale one.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk) #1; while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk) #1; while (rdy_s !== 1'b1);
    q = rd_s;
    hwdata <= ~d;
  endtask
endmodule // host_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the display command block.
`default_nettype none
module tb;
  import oled_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hrdy, pix, lit, on, gnd, hiz;
  logic [1:0]  htrans;
  logic [7:0]  contrast;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic        rext, mstb, act;
  logic [2:0]  mpg;
  logic [5:0]  srow, sram;
  logic [6:0]  mseg;
  logic [7:0]  mdat;
  logic [63:0] rdo;
  int failures, cmp_count, cyc, i;
  logic [31:0] rowq [4] = '{32'h109, 32'h3C0105, 32'h32003B, 32'h108};
  host_model host (.hclk(hclk), .hreadyout(hrdy), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata));
  oled_display_command_config uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(), .hrdata(hrdata), .pixel_mem_bit(pix),
    .scan_row_index(srow), .pixel_lit(lit), .contrast_level(contrast),
    .reference_current_external(rext), .display_on(on),
    .segment_ground(gnd), .row_output_hiz(hiz), .row_driver_output(rdo),
    .scan_ram_row(sram), .scan_row_active(act), .mem_write_strobe(mstb),
    .mem_segment(mseg), .mem_page(mpg), .mem_write_data(mdat));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic test_done();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_contrast();
    rd(CONFIG_OFFSET);
    chk(q, 32'h7F3F0000);
    wr(CMD_OFFSET, OP_CONTRAST);
    chk(contrast, 8'h7F);
    wr(CMD_OFFSET, 8'hFF);
    chk(contrast, 8'hFF);
  endtask
  task automatic t_window();
    wr(CMD_OFFSET, OP_PAGE_WINDOW);
    wr(CMD_OFFSET, 8'h01);
    wr(CMD_OFFSET, 8'h06);
    rd(POINTER_OFFSET);
    chk(q, 32'h20100);
    wr(CMD_OFFSET, OP_ADDR_MODE);
    wr(CMD_OFFSET, 8'h01);
    for (i = 0; i < 6; i++) wr(DATA_OFFSET, 8'h5A);
    rd(POINTER_OFFSET);
    chk(q, 32'h10101);
    wr(CMD_OFFSET, OP_ADDR_MODE);
    wr(CMD_OFFSET, 8'h00);
    wr(CMD_OFFSET, OP_COL_WINDOW);
    wr(CMD_OFFSET, 8'h7E);
    wr(CMD_OFFSET, 8'h7F);
    for (i = 0; i < 12; i++) wr(DATA_OFFSET, 8'hA5);
    rd(POINTER_OFFSET);
    chk(q, 32'h17E);
  endtask
  task automatic t_display();
    rd(STATUS_OFFSET);
    chk(q, 32'h40);
    pix <= 1'b0;
    wr(CMD_OFFSET, 8'hA7);
    wr(CMD_OFFSET, 8'hAF);
    @(posedge hclk) #1;
    chk({on, hiz, lit}, 3'h5);
    wr(CMD_OFFSET, 8'hA6);
    wr(CMD_OFFSET, 8'hA5);
    @(posedge hclk) #1;
    chk(lit, 1'h1);
    wr(CMD_OFFSET, 8'hAE);
    @(posedge hclk) #1;
    chk({on, gnd, hiz}, 3'h3);
  endtask
  task automatic t_rowmap();
    wr(CMD_OFFSET, OP_OFFSET);
    wr(CMD_OFFSET, 8'h08);
    wr(CMD_OFFSET, 8'h41);
    wr(CMD_OFFSET, OP_MUX);
    wr(CMD_OFFSET, 8'h37);
    rd(CONFIG_OFFSET);
    chk(q, 32'hFF370801);
    for (i = 0; i < 4; i++) begin
      if (i == 3) wr(CMD_OFFSET, 8'hC8);
      wr(ROWQ_OFFSET, rowq[i][23:16]);
      rd(ROWQ_OFFSET);
      chk(q, rowq[i]);
    end
  endtask
  task automatic t_page();
    chk(rext, 1'h1);
    wr(CMD_OFFSET, OP_REF_SELECT);
    wr(CMD_OFFSET, 8'h10);
    chk(rext, 1'h0);
    wr(CMD_OFFSET, OP_ADDR_MODE);
    wr(CMD_OFFSET, 8'h02);
    wr(CMD_OFFSET, 8'hB3);
    wr(CMD_OFFSET, 8'h15);
    wr(CMD_OFFSET, 8'h02);
    wr(CMD_OFFSET, 8'hA1);
    wr(DATA_OFFSET, 8'h3C);
    chk({mstb, mseg, mpg, mdat}, {1'h1, 7'h2D, 3'h3, 8'h3C});
    rd(POINTER_OFFSET);
    chk(q, 32'h20353);
    wr(CMD_OFFSET, 8'hAF);
    @(posedge hclk) #1;
    chk(rdo[39:8], 32'hFFFFFF00);
    chk({act, sram}, {1'h1, 6'h38});
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    hresetn = 1'b0;
    pix = 1'b0;
    srow = 6'h10;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk) #1;
    t_contrast();
    t_window();
    t_display();
    t_rowmap();
    t_page();
    test_done();
  end
endmodule // tb
`default_nettype wire
